// ===== rtl/i2czl_pkg.sv
// Shared constants and types of the I2C control-register-zero block
package i2czl_pkg;
  // System clock rate
  localparam int CLK_MHZ = 125;
  // Register byte addresses on APB
  localparam logic [7:0] A_CTRL0 = 8'h00;
  localparam logic [7:0] A_CLKCTL = 8'h04;
  localparam logic [7:0] A_SLVADR = 8'h08;
  localparam logic [7:0] A_SHIFT = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_CTRL4 = 8'h14;
  localparam logic [7:0] A_IRQST = 8'h18;
  localparam logic [7:0] A_IRQMSK = 8'h1c;
  // Control register zero fields
  localparam int CZ_BC_LSB = 0;
  localparam int CZ_EN = 3;
  localparam int CZ_FMT = 4;
  // Clock control register field
  localparam int CC_ACK = 0;
  // Slave address field lowest bit
  localparam int SA_LSB = 1;
  // Status register fields
  localparam int ST_GC = 1;
  localparam int ST_ADDRD = 2;
  localparam int ST_ARBL = 3;
  localparam int ST_PIN = 4;
  localparam int ST_BUSY = 5;
  localparam int ST_XMIT = 6;
  localparam int ST_MSEL = 7;
  // Control register four field
  localparam int C4_TFLAG = 0;
  // Interrupt status and mask fields
  localparam int NEV = 4;
  localparam int EV_BYTE = 0;
  localparam int EV_TOUT = 1;
  localparam int EV_START = 2;
  localparam int EV_STOP = 3;
  // Reset values
  localparam logic [2:0] BC_RST = 3'h0;
  localparam logic [6:0] SADR_RST = 7'h00;
  localparam logic [7:0] SHIFT_RST = 8'h00;
  localparam logic [NEV-1:0] IMSK_RST = 4'h0;
  // Address byte length after START, and general call value
  localparam logic [3:0] ADDR_BITS = 4'h8;
  localparam logic [7:0] GCALL = 8'h00;
  // Clock-high time that flags a stuck bus
  localparam int TOUT_NS = 20000;
  localparam int TOUT_CYC = TOUT_NS * CLK_MHZ / 1000;
  // Frame phase
  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10,
    PH_SKIP = 2'b11
  } i2czl_phase_t;
endpackage

// ===== rtl/i2czl_line.sv
// Pin synchroniser and SCL edge, START and STOP detector
`timescale 1ns/1ps
module i2czl_line (
  input wire logic clock, // System clock
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic scl_i, // SCL pin level
  input wire logic sda_i, // SDA pin level
  output logic scl_q, // Synchronised SCL
  output logic sda_q, // Synchronised SDA
  output logic scl_rise, // SCL rose
  output logic scl_fall, // SCL fell
  output logic start_det, // START seen
  output logic stop_det // STOP seen
);
  typedef struct packed {
    logic [1:0] m;
    logic [1:0] s;
    logic [1:0] p;
    logic rise;
    logic fall;
    logic start;
    logic stop;
  } i2czl_line_t;

  i2czl_line_t r;
  i2czl_line_t n;

  // Stage m is read only by stage s; edges compare s against p
  always_comb begin
    n = r;
    n.m = {scl_i, sda_i};
    n.s = r.m;
    n.p = r.s;
    n.rise = r.s[1] & ~r.p[1];
    n.fall = ~r.s[1] & r.p[1];
    // SDA moving while SCL stays high marks a condition
    n.start = r.s[1] & r.p[1] & ~r.s[0] & r.p[0];
    n.stop = r.s[1] & r.p[1] & r.s[0] & ~r.p[0];
  end

  // Idle bus is high, so reset to high avoids a false START
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= '{m: 2'h3, s: 2'h3, p: 2'h3, default: 1'b0};
    end else begin
      r <= n;
    end
  end

  assign scl_q = r.p[1];
  assign sda_q = r.p[0];
  assign scl_rise = r.rise;
  assign scl_fall = r.fall;
  assign start_det = r.start;
  assign stop_det = r.stop;
endmodule

// ===== rtl/i2czl_top.sv
// Control-register-zero logic of a multi-master I2C interface with APB access
`timescale 1ns/1ps
module i2czl_top #(
  parameter int TOUT_CYCLES = i2czl_pkg::TOUT_CYC
) (
  input wire logic clock, // System clock, 125 MHz
  input wire logic resetn, // Asynchronous reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic scl_i, // SCL pin level
  output logic scl_o, // SCL drive value
  output logic scl_oe, // SCL pulled low
  input wire logic sda_i, // SDA pin level
  output logic sda_o, // SDA drive value
  output logic sda_oe, // SDA pulled low
  output logic irq // Interrupt, level
);
  localparam int TW = $clog2(TOUT_CYCLES + 1);

  typedef struct packed {
    // Register fields
    logic [2:0] bc;
    logic en;
    logic fmt;
    logic ackclk;
    logic [6:0] sadr;
    logic [7:0] shift;
    // Status flags seen by software
    logic busy;
    logic pin;
    logic addrd;
    logic gc;
    logic xmit;
    logic tflag;
    // Engine state
    logic [TW-1:0] tcnt;
    i2czl_pkg::i2czl_phase_t phase;
    logic [3:0] bitcnt;
    // Registered outputs, with interrupt status and mask
    logic scl_oe;
    logic sda_oe;
    logic [i2czl_pkg::NEV-1:0] ist;
    logic [i2czl_pkg::NEV-1:0] imk;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } i2czl_top_t;

  i2czl_top_t r;
  i2czl_top_t n;

  logic ln_scl;
  logic ln_sda;
  logic ln_rise;
  logic ln_fall;
  logic ln_start;
  logic ln_stop;

  // Bits in a byte; a zero field means a full byte of eight
  function automatic logic [3:0] nbits(input logic [2:0] bc);
    nbits = (bc == 3'h0) ? 4'h8 : {1'b0, bc};
  endfunction

  // Whether a received address byte opens a transfer
  function automatic logic accept(input logic [7:0] adr, input logic [6:0] sadr, input logic fmt);
    accept = fmt | (adr[7:1] == sadr) | (adr == i2czl_pkg::GCALL);
  endfunction

  // Whether an APB address is mapped
  function automatic logic mapped(input logic [7:0] a);
    case (a)
      i2czl_pkg::A_CTRL0, i2czl_pkg::A_CLKCTL, i2czl_pkg::A_SLVADR, i2czl_pkg::A_SHIFT,
      i2czl_pkg::A_STATUS, i2czl_pkg::A_CTRL4, i2czl_pkg::A_IRQST, i2czl_pkg::A_IRQMSK: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // Pin conditioning; the link clock is only sampled, never used as a clock
  i2czl_line i2czl_line_inst (
    .clock(clock),
    .resetn(resetn),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_q(ln_scl),
    .sda_q(ln_sda),
    .scl_rise(ln_rise),
    .scl_fall(ln_fall),
    .start_det(ln_start),
    .stop_det(ln_stop)
  );

  logic setup;
  logic acc;
  logic wr;
  logic rd;
  logic [i2czl_pkg::NEV-1:0] ev;
  logic [i2czl_pkg::NEV-1:0] clr;
  logic [3:0] blen;
  logic [3:0] tgt;
  logic [7:0] stv;
  logic [31:0] rdv;

  // Next state of the whole block
  always_comb begin
    n = r;
    ev = '0;
    setup = psel & ~penable;
    acc = psel & penable & r.pready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;

    // Status view; master select and arbitration lost stay 0 in this slave
    stv = 8'h00;
    stv[i2czl_pkg::ST_GC] = r.gc;
    stv[i2czl_pkg::ST_ADDRD] = r.addrd;
    stv[i2czl_pkg::ST_PIN] = r.pin;
    stv[i2czl_pkg::ST_BUSY] = r.busy;
    stv[i2czl_pkg::ST_XMIT] = r.xmit;

    // Read data is captured in the setup cycle, answered one cycle later
    rdv = 32'h0000_0000;
    case (paddr)
      i2czl_pkg::A_CTRL0: begin
        rdv[i2czl_pkg::CZ_BC_LSB +: 3] = r.bc;
        rdv[i2czl_pkg::CZ_EN] = r.en;
        rdv[i2czl_pkg::CZ_FMT] = r.fmt;
      end
      i2czl_pkg::A_CLKCTL: rdv[i2czl_pkg::CC_ACK] = r.ackclk;
      i2czl_pkg::A_SLVADR: rdv[i2czl_pkg::SA_LSB +: 7] = r.sadr;
      i2czl_pkg::A_SHIFT: rdv[7:0] = r.shift;
      i2czl_pkg::A_STATUS: rdv[7:0] = stv;
      i2czl_pkg::A_CTRL4: rdv[i2czl_pkg::C4_TFLAG] = r.tflag;
      i2czl_pkg::A_IRQST: rdv[i2czl_pkg::NEV-1:0] = r.ist;
      i2czl_pkg::A_IRQMSK: rdv[i2czl_pkg::NEV-1:0] = r.imk;
      default: rdv = 32'h0000_0000;
    endcase
    n.pready = setup;
    // Any address off the map, aligned or not, answers with an error
    n.pslverr = setup & ~mapped(paddr);
    if (setup) begin
      n.prdata = rdv;
    end

    // Register writes take effect at the completing access edge
    if (wr) begin
      case (paddr)
        i2czl_pkg::A_CTRL0: begin
          n.bc = pwdata[i2czl_pkg::CZ_BC_LSB +: 3];
          n.en = pwdata[i2czl_pkg::CZ_EN];
          n.fmt = pwdata[i2czl_pkg::CZ_FMT];
        end
        i2czl_pkg::A_CLKCTL: n.ackclk = pwdata[i2czl_pkg::CC_ACK];
        i2czl_pkg::A_SLVADR: n.sadr = pwdata[i2czl_pkg::SA_LSB +: 7];
        i2czl_pkg::A_SHIFT: begin
          // A byte loaded by software releases the held clock
          if (r.en) begin
            n.shift = pwdata[7:0];
            n.pin = 1'b1;
            n.scl_oe = 1'b0;
            n.sda_oe = r.xmit & ~pwdata[7];
          end
        end
        i2czl_pkg::A_IRQMSK: n.imk = pwdata[i2czl_pkg::NEV-1:0];
        default: n.imk = r.imk;
      endcase
    end

    // Byte length: address byte is always eight, data bytes follow the field
    blen = (r.phase == i2czl_pkg::PH_ADDR) ? i2czl_pkg::ADDR_BITS : nbits(r.bc);
    tgt = blen + {3'h0, r.ackclk};

    // Bus engine runs only while enabled
    if (r.en) begin
      // START restarts address reception from any phase, even mid-byte
      if (ln_start) begin
        n.busy = 1'b1;
        n.phase = i2czl_pkg::PH_ADDR;
        n.bitcnt = 4'h0;
        n.addrd = 1'b0;
        n.gc = 1'b0;
        n.xmit = 1'b0;
        n.sda_oe = 1'b0;
        n.scl_oe = 1'b0;
        ev[i2czl_pkg::EV_START] = 1'b1;
      end else if (ln_stop) begin
        // STOP frees the bus and drops every role
        n.busy = 1'b0;
        n.phase = i2czl_pkg::PH_IDLE;
        n.bitcnt = 4'h0;
        n.addrd = 1'b0;
        n.gc = 1'b0;
        n.xmit = 1'b0;
        n.sda_oe = 1'b0;
        n.scl_oe = 1'b0;
        ev[i2czl_pkg::EV_STOP] = 1'b1;
      end else if (ln_rise && r.phase != i2czl_pkg::PH_IDLE) begin
        // Data bits shift in on rising SCL; the acknowledge bit does not
        if (r.bitcnt < blen) begin
          n.shift = {r.shift[6:0], ln_sda};
        end
        if (r.bitcnt + 4'h1 == tgt) begin
          n.bitcnt = 4'h0;
          case (r.phase)
            i2czl_pkg::PH_ADDR: begin
              // Field cleared on every address byte, matched or not
              n.bc = 3'h0;
              if (accept(n.shift, r.sadr, r.fmt)) begin
                n.phase = i2czl_pkg::PH_DATA;
                n.pin = 1'b0;
                ev[i2czl_pkg::EV_BYTE] = 1'b1;
                if (!r.fmt) begin
                  n.addrd = 1'b1;
                  n.gc = (n.shift == i2czl_pkg::GCALL);
                  n.xmit = n.shift[0] & (n.shift != i2czl_pkg::GCALL);
                end
              end else begin
                // No match: sit out the rest of the frame
                n.phase = i2czl_pkg::PH_SKIP;
              end
            end
            i2czl_pkg::PH_DATA: begin
              // Software reloads the field before the next byte
              n.bc = 3'h0;
              n.pin = 1'b0;
              ev[i2czl_pkg::EV_BYTE] = 1'b1;
            end
            default: n.phase = r.phase;
          endcase
        end else begin
          n.bitcnt = r.bitcnt + 4'h1;
        end
      end else if (ln_fall && (r.phase == i2czl_pkg::PH_ADDR || r.phase == i2czl_pkg::PH_DATA)) begin
        // Drive changes only while SCL is low
        n.sda_oe = 1'b0;
        if (r.phase == i2czl_pkg::PH_DATA && !r.pin) begin
          // Hold SCL low until software services the byte
          n.scl_oe = 1'b1;
        end else if (r.bitcnt < blen) begin
          // Transmit: the next bit sits at the top of the shift register
          if (r.xmit) begin
            n.sda_oe = ~r.shift[7];
          end
        end else if (r.bitcnt == blen && r.ackclk && !r.xmit) begin
          // The shift register holds the whole received byte by now
          // Acknowledge only a byte this device takes part in
          if (r.phase == i2czl_pkg::PH_DATA || accept(r.shift, r.sadr, r.fmt)) begin
            n.sda_oe = 1'b1;
          end
        end
      end

      // Stuck-high SCL during a busy bus counts towards a timeout
      if (r.busy && ln_scl) begin
        // Counter parks at its limit and the flag stays set until disable, so flag and event fire only once
        if (r.tcnt != TW'(TOUT_CYCLES - 1)) begin
          n.tcnt = r.tcnt + 1'b1;
        end else if (!r.tflag) begin
          n.tflag = 1'b1;
          ev[i2czl_pkg::EV_TOUT] = 1'b1;
        end
      end else begin
        n.tcnt = '0;
      end
    end

    // Uses the written enable so clearing starts in the write cycle itself
    if (!n.en) begin
      n.sda_oe = 1'b0;
      n.scl_oe = 1'b0;
      // Bit count field is kept, so software still reads its last setting
      n.xmit = 1'b0;
      n.pin = 1'b1;
      n.busy = 1'b0;
      n.addrd = 1'b0;
      n.gc = 1'b0;
      n.tflag = 1'b0;
      n.tcnt = '0;
      n.bitcnt = 4'h0;
      n.phase = i2czl_pkg::PH_IDLE;
      ev = '0;
    end

    // Read clears only bits that were returned, so a new event survives
    clr = '0;
    if (rd && paddr == i2czl_pkg::A_IRQST) begin
      clr = r.prdata[i2czl_pkg::NEV-1:0];
    end
    n.ist = (r.ist & ~clr) | ev;
    // Level output follows the status and mask of this same edge
    n.irq = |(n.ist & n.imk);
  end

  // Single state register
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      r <= '{
        bc: i2czl_pkg::BC_RST,
        sadr: i2czl_pkg::SADR_RST,
        shift: i2czl_pkg::SHIFT_RST,
        pin: 1'b1,
        tcnt: '0,
        phase: i2czl_pkg::PH_IDLE,
        bitcnt: 4'h0,
        ist: '0,
        imk: i2czl_pkg::IMSK_RST,
        prdata: 32'h0000_0000,
        default: 1'b0
      };
    end else begin
      r <= n;
    end
  end

  // Outputs straight from the state register; pins are open drain
  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign scl_oe = r.scl_oe;
  assign sda_oe = r.sda_oe;
  // Drive values stay low; only the enables pull the wires
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign irq = r.irq;
endmodule

// ===== tb/i2czl_chk.sv
// Port-level assertions for the control-register-zero block
`timescale 1ns/1ps
module i2czl_chk #(
  parameter int TOUT_CYCLES = 50
) (
  input wire logic clock, // System clock
  input wire logic resetn, // Reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB direction
  input wire logic [7:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  input wire logic [31:0] prdata, // APB read data
  input wire logic pready, // APB ready
  input wire logic pslverr, // APB error
  input wire logic scl_o, // SCL value
  input wire logic scl_oe, // SCL enable
  input wire logic sda_o, // SDA value
  input wire logic sda_oe, // SDA enable
  input wire logic irq // Interrupt
);
  logic en_q;
  logic [3:0] msk_q;
  logic wr_done;
  logic rd_dis;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  // Writes land only at the access edge with ready high
  assign wr_done = psel && penable && pready && pwrite;
  assign rd_dis = pready && !pwrite && !en_q;
  // Shadow copies of enable and mask, so checks need no internal probes
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      en_q <= 1'b0;
      msk_q <= 4'h0;
    end else if (wr_done && paddr == i2czl_pkg::A_CTRL0) begin
      en_q <= pwdata[i2czl_pkg::CZ_EN];
    end else if (wr_done && paddr == i2czl_pkg::A_IRQMSK) begin
      msk_q <= pwdata[3:0];
    end
  end
  apb_answer_a: assert property (psel && !penable |=> pready)
    else $error("No ready after setup");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("Ready longer than one cycle");
  unmapped_err_a: assert property (pready |-> pslverr == (paddr > i2czl_pkg::A_IRQMSK || paddr[1:0] != 2'h0))
    else $error("Error flag wrong for address");
  upper_zero_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("Upper read bits not zero");
  pins_float_a: assert property (!en_q |-> !sda_oe && !scl_oe)
    else $error("Pin driven while disabled");
  open_drain_a: assert property (!scl_o && !sda_o)
    else $error("Pin drive value not low");
  status_forced_a: assert property (rd_dis && paddr == i2czl_pkg::A_STATUS |-> prdata[7:1] == 7'h08)
    else $error("Status flags not forced");
  timeout_cleared_a: assert property (rd_dis && paddr == i2czl_pkg::A_CTRL4 |-> !prdata[i2czl_pkg::C4_TFLAG])
    else $error("Timeout flag set while disabled");
  irq_masked_a: assert property (msk_q == 4'h0 |-> !irq)
    else $error("Interrupt with all masked");
endmodule
bind i2czl_top i2czl_chk #(.TOUT_CYCLES(TOUT_CYCLES)) i2czl_chk_inst (
  .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_o(scl_o),
  .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));

// ===== tb/i2czl_master_bfm.sv
// Behavioural I2C bus master on the far side of the link
`timescale 1ns/1ps
module i2czl_master_bfm (
  input wire logic scl, // Resolved SCL wire
  input wire logic sda, // Resolved SDA wire
  output logic scl_low, // Pull SCL low
  output logic sda_low // Pull SDA low
);
  localparam int QTR = 40;
  // Released lines float high through the pull-ups
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // SDA falls while SCL is high; non-blocking so pins never race the sampling edge
  task automatic start();
    sda_low <= 1'b1;
    #(2 * QTR);
    scl_low <= 1'b1;
    #QTR;
  endtask
  // Data moves only while SCL is low; a stretching slave is waited out
  task automatic bit_tx(input logic b, output logic s);
    sda_low <= !b;
    #QTR;
    scl_low <= 1'b0;
    wait (scl === 1'b1);
    #QTR;
    s = sda;
    #QTR;
    scl_low <= 1'b1;
    #QTR;
  endtask
  // MSB first, then a released acknowledge bit
  task automatic byte_tx(input logic [7:0] d, input int n, output logic ack);
    logic s;
    for (int i = n - 1; i >= 0; i--) begin
      bit_tx(d[i], s);
    end
    bit_tx(1'b1, ack);
  endtask
  // SDA rises while SCL is high
  task automatic stop();
    sda_low <= 1'b1;
    #QTR;
    scl_low <= 1'b0;
    wait (scl === 1'b1);
    #QTR;
    sda_low <= 1'b0;
    #(2 * QTR);
  endtask
endmodule

// ===== tb/tb_i2c_control_zero_logic.sv
// Directed testbench for the control-register-zero block
`timescale 1ns/1ps
module tb_i2c_control_zero_logic;
  logic clock, resetn, psel, penable, pwrite, pready, pslverr;
  logic scl_oe, sda_oe, irq, m_scl, m_sda, er, ack;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  int failures, checks;
  int cyc = 0;
  // Open-drain wires with pull-ups
  wire scl_w = !(scl_oe | m_scl);
  wire sda_w = !(sda_oe | m_sda);
  i2czl_top #(.TOUT_CYCLES(50)) i2czl_top_inst (
    .clock(clock), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl_w), .scl_o(),
    .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(), .sda_oe(sda_oe), .irq(irq));
  i2czl_master_bfm i2czl_master_bfm_inst (.scl(scl_w), .sda(sda_w), .scl_low(m_scl), .sda_low(m_sda));
  // 125 MHz system clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One APB transfer; request held until ready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    apb(1'b0, a, 32'h0);
    cmp(rd[7:0] & m, x);
  endtask
  task automatic frame(input logic [7:0] a, input logic x);
    i2czl_master_bfm_inst.start();
    i2czl_master_bfm_inst.byte_tx(a, 8, ack);
    cmp({7'h0, ack}, {7'h0, x});
  endtask
  // Writing the shift register frees the held clock before STOP
  task automatic finish_frame();
    wr(i2czl_pkg::A_SHIFT, 8'h00);
    i2czl_master_bfm_inst.stop();
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    failures = 0;
    checks = 0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    rdc(i2czl_pkg::A_CTRL0, 8'hff, 8'h00);
    rdc(i2czl_pkg::A_STATUS, 8'hfe, 8'h10);
    rdc(i2czl_pkg::A_CTRL4, 8'h01, 8'h00);
    rdc(i2czl_pkg::A_IRQMSK, 8'hff, 8'h00);
    apb(1'b0, 8'h20, 32'h0);
    cmp({7'h0, er}, 8'h01);
    wr(i2czl_pkg::A_SHIFT, 8'ha5);
    rdc(i2czl_pkg::A_SHIFT, 8'hff, 8'h00);
    wr(i2czl_pkg::A_SLVADR, 8'h54);
    wr(i2czl_pkg::A_CLKCTL, 8'h01);
    wr(i2czl_pkg::A_IRQMSK, 8'h01);
    wr(i2czl_pkg::A_CTRL0, 8'h0b);
    wr(i2czl_pkg::A_SHIFT, 8'ha5);
    rdc(i2czl_pkg::A_SHIFT, 8'hff, 8'ha5);
    frame(8'h54, 1'b0);
    rdc(i2czl_pkg::A_CTRL0, 8'h07, 8'h00);
    rdc(i2czl_pkg::A_IRQST, 8'h0f, 8'h05);
    wr(i2czl_pkg::A_CTRL0, 8'h0b);
    wr(i2czl_pkg::A_SHIFT, 8'h00);
    i2czl_master_bfm_inst.byte_tx(8'h05, 3, ack);
    cmp({7'h0, ack}, 8'h00);
    repeat (8) @(posedge clock);
    cmp({7'h0, irq}, 8'h01);
    rdc(i2czl_pkg::A_CTRL0, 8'h07, 8'h00);
    rdc(i2czl_pkg::A_IRQST, 8'h01, 8'h01);
    repeat (2) @(posedge clock);
    cmp({7'h0, irq}, 8'h00);
    finish_frame();
    frame(8'h66, 1'b1);
    i2czl_master_bfm_inst.stop();
    frame(8'h00, 1'b0);
    finish_frame();
    // Read request: addressed and transmitting; a released first bit lets STOP through
    frame(8'h55, 1'b0);
    rdc(i2czl_pkg::A_STATUS, 8'h46, 8'h44);
    wr(i2czl_pkg::A_SHIFT, 8'hff);
    i2czl_master_bfm_inst.stop();
    wr(i2czl_pkg::A_CTRL0, 8'h18);
    frame(8'h66, 1'b0);
    finish_frame();
    // Old byte events cleared so only the masked START and timeout events can be pending
    rdc(i2czl_pkg::A_IRQST, 8'h01, 8'h01);
    // Stuck bus: START then SCL left high, timeout event stays masked
    i2czl_master_bfm_inst.start();
    i2czl_master_bfm_inst.scl_low <= 1'b0;
    repeat (100) @(posedge clock);
    rdc(i2czl_pkg::A_CTRL4, 8'h01, 8'h01);
    cmp({7'h0, irq}, 8'h00);
    rdc(i2czl_pkg::A_IRQST, 8'h02, 8'h02);
    rdc(i2czl_pkg::A_STATUS, 8'h20, 8'h20);
    wr(i2czl_pkg::A_CTRL0, 8'h00);
    rdc(i2czl_pkg::A_STATUS, 8'hfe, 8'h10);
    rdc(i2czl_pkg::A_CTRL4, 8'h01, 8'h00);
    i2czl_master_bfm_inst.stop();
    wr(i2czl_pkg::A_CTRL0, 8'h08);
    frame(8'h54, 1'b0);
    finish_frame();
    print_verdict();
  end
endmodule
